// ==== adm_analog_model.sv ====
`timescale 1ns/1ps

// ----
// analog core stand-in: one fixed level per input
// ----
module adm_analog_model (
  input wire logic clk_in,
  input wire logic [3:0] sel_ch_in,
  input wire logic sel_ref_in,
  input wire logic converting_in,
  output logic [9:0] conv_data_out
);
  logic [9:0] noise_ff = 10'h2c3;
  logic [9:0] level;

  always @(posedge clk_in) begin
    noise_ff <= noise_ff + 10'h135;
  end

  assign level = sel_ref_in ? 10'h3a5 : {1'b0, sel_ch_in, 5'h16};
  // outside a conversion the value moves, so a mistimed sample shows up
  assign conv_data_out = converting_in ? level : noise_ff;
endmodule

// ==== adm_defines.svh ====
`ifndef ADM_DEFINES_SVH
`define ADM_DEFINES_SVH

// ----------------------------------------------------------------------
// timing counts, in converter clock ticks
// ----------------------------------------------------------------------
`define ADM_START_CYC 6'h01
`define ADM_ASSIST_CYC 6'h02
`define ADM_CONV_CYC 6'h28
`define ADM_GAP_CYC 6'h01
`define ADM_END_CYC 6'h02

// ----------------------------------------------------------------------
// slots and sweep groups
// ----------------------------------------------------------------------
`define ADM_ROT_LAST_SLOT 3'h7
`define ADM_SWEEP_LAST_WIDE 2'h3
`define ADM_SWEEP_LAST_NARROW 2'h1
`define ADM_HIGH_GROUP_BASE 4'h8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ADM_SYNC_IDLE 1'b1

`endif

// ==== adm_edge_sync.sv ====
`timescale 1ns/1ps
`include "adm_defines.svh"

// two-stage synchroniser with falling-edge pulse
module adm_edge_sync (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic pin_in,
  output logic fall_out
);
  import adm_pkg::*;

  adm_sync_state_t st_ff, nxt_st;

  always_comb begin
    nxt_st.meta = pin_in;
    nxt_st.sync = st_ff.meta;
    nxt_st.prev = st_ff.sync;
  end

  // idle high so a released reset looks like a falling edge only if the pin is still low
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_ff <= {3{`ADM_SYNC_IDLE}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fall_out = st_ff.prev & ~st_ff.sync;
endmodule

// ==== adm_mode_sequencer.sv ====
`timescale 1ns/1ps
`include "adm_defines.svh"

// Overview of operation
// (R1) open-circuit assist on: precharge or discharge before each conversion
// (R2) software enables the assist first, then picks its polarity
// (R3) single conversion mode converts one chosen input exactly once
// (R4) single-channel input comes from channel and group selects, or reference
// (R5) every mode supports 8-bit and 10-bit results
// (R6) software, compare timer and external trigger can start every mode
// (R7) trigger field: 00 software, 10 compare timer, 11 external falling edge
// (R8) one-shot with software trigger clears the run flag at completion
// (R9) single conversion raises the interrupt request at completion
// (R10) repeating modes run until software writes 0 to the run flag
// (R11) quiet repeat mode converts continuously and never interrupts
// (R12) single-channel results go to a fixed slot per input
// (R13) rotating repeat mode fills slots 0 to 7, then wraps
// (R14) rotating repeat interrupts on each slot 7 write and keeps going
// (R15) sweep mode converts channel pair 0-1, pair 8-9 or quad 8-11
// (R16) sweep mode clears the run flag after the whole group
// (R17) sweep mode interrupts only after the last input
// (R18) sweep results go to slots 0 to 3 by position
// (R19) clearing the run flag mid-conversion gives no interrupt
// (R20) sweep converts upward with a gap between channels
module adm_mode_sequencer #(
  parameter int AD_DIV = 1
) (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire adm_pkg::adm_cfg_t CFG_IN,
  input wire logic RUN_WR_IN,
  input wire logic RUN_WR_DATA_IN,
  input wire logic TIMER_MATCH_IN,
  input wire logic EXT_TRIG_IN,
  input wire logic [9:0] CONV_DATA_IN,
  output logic RUN_FLAG_OUT,
  output logic IRQ_OUT,
  output adm_pkg::adm_res_t RES_OUT,
  output logic [3:0] SEL_CH_OUT,
  output logic SEL_REF_OUT,
  output logic PRECHARGE_OUT,
  output logic DISCHARGE_OUT,
  output logic CONVERTING_OUT
);
  import adm_pkg::*;

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  adm_seq_state_t st_ff, nxt_st;
  logic ad_tick;
  logic ext_fall;
  logic sw_set;
  logic sw_clr;
  logic hw_trig;
  logic step_done;
  logic last_pos;
  logic [1:0] last_idx;
  logic [4:0] cur_sel;
  logic [4:0] nxt_sel;
  logic [2:0] cur_slot;
  adm_fsm_t entry_fsm;
  logic [5:0] entry_cnt;

  adm_tick_div #(.DIV(AD_DIV)) u_div (
    .clk_in(SYS_CLK_IN),
    .reset_in(RESET_IN),
    .tick_out(ad_tick)
  );

  adm_edge_sync u_ext (
    .clk_in(SYS_CLK_IN),
    .reset_in(RESET_IN),
    .pin_in(EXT_TRIG_IN),
    .fall_out(ext_fall)
  );

  // returns {reference, channel}
  function automatic logic [4:0] chan_of(input adm_cfg_t c,
                                         input logic [1:0] p);
    logic [3:0] base;
    base = 4'h0;
    if (c.mode == ADM_SWEEP) begin
      // (R15) group choice
      base = (c.sweep_width_bit || c.group_select != 2'h0) ?
             `ADM_HIGH_GROUP_BASE : 4'h0;
      chan_of = {1'b0, base + {2'h0, p}};
    end else if (c.extended_input_select) begin
      chan_of = 5'h10;
    end else begin
      // (R4) group select picks the upper bank
      chan_of = {1'b0, c.group_select[0], c.channel_select};
    end
  endfunction

  // (R12) slot per single-channel input
  function automatic logic [2:0] slot_of(input logic [4:0] s);
    logic [2:0] slot;
    slot = 3'h0;
    if (!s[4]) begin
      unique case (s[3:0])
        4'h1, 4'h9: slot = 3'h1;
        4'ha: slot = 3'h2;
        4'hb: slot = 3'h3;
        4'h5: slot = 3'h5;
        4'h6: slot = 3'h6;
        default: slot = 3'h0;
      endcase
    end
    slot_of = slot;
  endfunction

  // (R5) 8-bit results keep the upper bits, right aligned
  function automatic logic [9:0] fit(input logic res10, input logic [9:0] d);
    fit = res10 ? d : {2'h0, d[9:2]};
  endfunction

  // --------------------------------------------------------------------
  // trigger and step decode
  // --------------------------------------------------------------------
  assign sw_set = RUN_WR_IN & RUN_WR_DATA_IN;
  assign sw_clr = RUN_WR_IN & ~RUN_WR_DATA_IN;
  // (R6) hardware start sources, (R7) decoded by trigger field
  assign hw_trig = (st_ff.cfg.trig == ADM_TRIG_TIMER && TIMER_MATCH_IN) ||
                   (st_ff.cfg.trig == ADM_TRIG_EXT && ext_fall);
  assign step_done = ad_tick && st_ff.cnt == 6'h00;
  assign last_idx = st_ff.cfg.sweep_width_bit ? `ADM_SWEEP_LAST_WIDE :
                    `ADM_SWEEP_LAST_NARROW;
  assign last_pos = st_ff.pos == last_idx;
  assign cur_sel = chan_of(st_ff.cfg, st_ff.pos);
  // (R18) sweep slot follows position
  assign cur_slot = (st_ff.cfg.mode == ADM_SWEEP) ? {1'b0, st_ff.pos} :
                    slot_of(cur_sel);
  // (R1) assist phase precedes every conversion when enabled
  assign entry_fsm = st_ff.cfg.open_detect_enable ? S_ASSIST : S_CONV;
  assign entry_cnt = st_ff.cfg.open_detect_enable ?
                     `ADM_ASSIST_CYC - 6'h01 : `ADM_CONV_CYC - 6'h01;

  // --------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.res.we = 1'b0;
    nxt_st.irq = 1'b0;
    nxt_sel = 5'h00;
    if (ad_tick && st_ff.cnt != 6'h00) begin
      nxt_st.cnt = st_ff.cnt - 6'h01;
    end
    unique case (st_ff.fsm)
      S_IDLE: begin
        // settings are frozen for the whole run
        if (sw_set) begin
          nxt_st.run = 1'b1;
          nxt_st.cfg = CFG_IN;
          nxt_st.rot = 3'h0;
          nxt_st.pos = 2'h0;
          nxt_st.cnt = `ADM_START_CYC - 6'h01;
          // (R7) software and reserved triggers start at once, timer and external arm
          nxt_st.fsm = (CFG_IN.trig == ADM_TRIG_TIMER ||
                        CFG_IN.trig == ADM_TRIG_EXT) ? S_ARMED : S_START;
        end
      end
      S_ARMED: begin
        // (R6) wait for the selected hardware event
        if (hw_trig) begin
          nxt_st.fsm = S_START;
          nxt_st.cnt = `ADM_START_CYC - 6'h01;
        end
      end
      S_START, S_GAP: begin
        if (step_done) begin
          nxt_st.fsm = entry_fsm;
          nxt_st.cnt = entry_cnt;
        end
      end
      S_ASSIST: begin
        if (step_done) begin
          nxt_st.fsm = S_CONV;
          nxt_st.cnt = `ADM_CONV_CYC - 6'h01;
        end
      end
      S_CONV: begin
        if (step_done) begin
          nxt_st.sample = CONV_DATA_IN;
          if (st_ff.cfg.mode == ADM_ONE_SHOT ||
              (st_ff.cfg.mode == ADM_SWEEP && last_pos)) begin
            // (R3) single pass ends through the end phase
            nxt_st.fsm = S_END;
            nxt_st.cnt = `ADM_END_CYC - 6'h01;
          end else begin
            nxt_st.res.we = 1'b1;
            nxt_st.res.data = fit(st_ff.cfg.res_10bit, CONV_DATA_IN);
            nxt_st.res.idx = cur_slot;
            if (st_ff.cfg.mode == ADM_REPEAT_ROT) begin
              // (R13) rotate through slots, wrapping after 7
              nxt_st.res.idx = st_ff.rot;
              nxt_st.rot = st_ff.rot + 3'h1;
              // (R14) interrupt on the slot 7 write, keep running
              nxt_st.irq = st_ff.rot == `ADM_ROT_LAST_SLOT;
            end
            // (R20) next channel upward after the gap
            if (st_ff.cfg.mode == ADM_SWEEP) begin
              nxt_st.pos = st_ff.pos + 2'h1;
            end
            // (R10) (R11) repeat modes loop; only rotating repeat interrupts, on slot 7
            nxt_st.fsm = S_GAP;
            nxt_st.cnt = `ADM_GAP_CYC - 6'h01;
          end
        end
      end
      S_END: begin
        if (step_done) begin
          nxt_st.res.we = 1'b1;
          nxt_st.res.data = fit(st_ff.cfg.res_10bit, st_ff.sample);
          nxt_st.res.idx = cur_slot;
          // (R9) (R17) completion interrupt after the last input
          nxt_st.irq = 1'b1;
          nxt_st.pos = 2'h0;
          // (R8) (R16) self-clear; a same-cycle software set wins
          if ((st_ff.cfg.mode == ADM_SWEEP ||
               st_ff.cfg.trig == ADM_TRIG_SOFT ||
               st_ff.cfg.trig == ADM_TRIG_RSVD) && !sw_set) begin
            nxt_st.run = 1'b0;
            nxt_st.fsm = S_IDLE;
          end else if (st_ff.cfg.trig == ADM_TRIG_TIMER ||
                       st_ff.cfg.trig == ADM_TRIG_EXT) begin
            nxt_st.fsm = S_ARMED;
          end else begin
            nxt_st.fsm = S_START;
            nxt_st.cnt = `ADM_START_CYC - 6'h01;
          end
        end
      end
    endcase
    // (R10) (R19) software stop aborts silently from any phase
    if (sw_clr && st_ff.fsm != S_IDLE) begin
      nxt_st.fsm = S_IDLE;
      nxt_st.run = 1'b0;
      nxt_st.res.we = 1'b0;
      nxt_st.irq = 1'b0;
      nxt_st.pos = 2'h0;
    end
    // outputs track the next phase so they leave straight from flops
    nxt_sel = chan_of(nxt_st.cfg, nxt_st.pos);
    nxt_st.ch = nxt_sel[3:0];
    nxt_st.ref_sel = nxt_sel[4];
    // (R1) polarity picks the supply or ground level
    nxt_st.pre = nxt_st.fsm == S_ASSIST && nxt_st.cfg.open_detect_polarity;
    nxt_st.dis = nxt_st.fsm == S_ASSIST && !nxt_st.cfg.open_detect_polarity;
    nxt_st.busy = nxt_st.fsm == S_CONV;
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      st_ff <= '0;
      st_ff.fsm <= S_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign RUN_FLAG_OUT = st_ff.run;
  assign IRQ_OUT = st_ff.irq;
  assign RES_OUT = st_ff.res;
  assign SEL_CH_OUT = st_ff.ch;
  assign SEL_REF_OUT = st_ff.ref_sel;
  assign PRECHARGE_OUT = st_ff.pre;
  assign DISCHARGE_OUT = st_ff.dis;
  assign CONVERTING_OUT = st_ff.busy;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RESET_IN);

  chk_assist_before_conv: assert property ( // (R1)
    $rose(st_ff.fsm == S_CONV) && st_ff.cfg.open_detect_enable
    |-> $past(PRECHARGE_OUT || DISCHARGE_OUT))
    else $error("conversion began without the assist phase");

  chk_assist_level_sel: assert property ( // (R1)
    st_ff.fsm == S_ASSIST
    |-> PRECHARGE_OUT == st_ff.cfg.open_detect_polarity &&
        DISCHARGE_OUT != st_ff.cfg.open_detect_polarity)
    else $error("assist level does not follow polarity");

  chk_timer_start_cause: assert property ( // (R7)
    st_ff.fsm == S_START && $past(st_ff.fsm) == S_ARMED &&
    st_ff.cfg.trig == ADM_TRIG_TIMER |-> $past(TIMER_MATCH_IN))
    else $error("timer-armed start without a compare match");

  chk_soft_shot_clear: assert property ( // (R8)
    IRQ_OUT && st_ff.cfg.mode == ADM_ONE_SHOT &&
    st_ff.cfg.trig == ADM_TRIG_SOFT && !$past(sw_set) |-> !RUN_FLAG_OUT)
    else $error("run flag still set after single conversion");

  chk_quiet_no_irq: assert property ( // (R11)
    st_ff.cfg.mode == ADM_REPEAT_QUIET |-> !IRQ_OUT)
    else $error("interrupt raised in quiet repeat mode");

  chk_single_slot_map: assert property ( // (R12)
    RES_OUT.we && (st_ff.cfg.mode == ADM_ONE_SHOT ||
                   st_ff.cfg.mode == ADM_REPEAT_QUIET)
    |-> RES_OUT.idx == slot_of({SEL_REF_OUT, SEL_CH_OUT}))
    else $error("single-channel result in wrong slot");

  chk_rot_irq_slot: assert property ( // (R14)
    IRQ_OUT && st_ff.cfg.mode == ADM_REPEAT_ROT
    |-> RES_OUT.we && RES_OUT.idx == 3'h7 && RUN_FLAG_OUT)
    else $error("rotating interrupt not tied to slot 7");

  chk_sweep_clear: assert property ( // (R16)
    IRQ_OUT && st_ff.cfg.mode == ADM_SWEEP && !$past(sw_set)
    |-> !RUN_FLAG_OUT && st_ff.fsm == S_IDLE)
    else $error("sweep finished but run flag stays set");

  chk_sweep_last_irq: assert property ( // (R17)
    IRQ_OUT && st_ff.cfg.mode == ADM_SWEEP
    |-> RES_OUT.idx == (st_ff.cfg.sweep_width_bit ? 3'h3 : 3'h1))
    else $error("sweep interrupt before the last input");

  chk_abort_silent: assert property ( // (R19)
    sw_clr && st_ff.fsm != S_IDLE
    |=> !IRQ_OUT && !RES_OUT.we && !RUN_FLAG_OUT ##1 !IRQ_OUT)
    else $error("software stop produced an interrupt or result");

  chk_soft_no_arm: assert property ( // (R7)
    $rose(RUN_FLAG_OUT) && st_ff.cfg.trig == ADM_TRIG_SOFT
    |-> st_ff.fsm == S_START)
    else $error("software-triggered run waited for a hardware event");

  chk_ext_start_cause: assert property ( // (R7)
    st_ff.fsm == S_START && $past(st_ff.fsm) == S_ARMED &&
    st_ff.cfg.trig == ADM_TRIG_EXT |-> $past(ext_fall))
    else $error("external-armed start without a falling edge");

  chk_repeat_stop_only: assert property ( // (R10)
    $fell(RUN_FLAG_OUT) && (st_ff.cfg.mode == ADM_REPEAT_QUIET ||
                            st_ff.cfg.mode == ADM_REPEAT_ROT)
    |-> $past(sw_clr))
    else $error("repeat mode stopped without a software clear");
endmodule

// ==== adm_pkg.sv ====
package adm_pkg;

  typedef enum logic [1:0] {
    ADM_ONE_SHOT = 2'h0,
    ADM_REPEAT_QUIET = 2'h1,
    ADM_REPEAT_ROT = 2'h2,
    ADM_SWEEP = 2'h3
  } adm_mode_t;

  typedef enum logic [1:0] {
    ADM_TRIG_SOFT = 2'h0,
    ADM_TRIG_RSVD = 2'h1,
    ADM_TRIG_TIMER = 2'h2,
    ADM_TRIG_EXT = 2'h3
  } adm_trig_t;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_ARMED = 7'h02,
    S_START = 7'h04,
    S_ASSIST = 7'h08,
    S_CONV = 7'h10,
    S_GAP = 7'h20,
    S_END = 7'h40
  } adm_fsm_t;

  typedef struct packed {
    adm_mode_t mode;
    adm_trig_t trig;
    logic [2:0] channel_select;
    logic [1:0] group_select;
    logic sweep_width_bit;
    logic extended_input_select;
    logic res_10bit;
    logic open_detect_enable;
    logic open_detect_polarity;
  } adm_cfg_t;

  typedef struct packed {
    logic we;
    logic [2:0] idx;
    logic [9:0] data;
  } adm_res_t;

  typedef struct packed {
    adm_fsm_t fsm;
    adm_cfg_t cfg;
    logic run;
    logic [5:0] cnt;
    logic [1:0] pos;
    logic [2:0] rot;
    logic [9:0] sample;
    adm_res_t res;
    logic irq;
    logic [3:0] ch;
    logic ref_sel;
    logic pre;
    logic dis;
    logic busy;
  } adm_seq_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } adm_div_state_t;

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } adm_sync_state_t;

endpackage

// ==== adm_tick_div.sv ====
`timescale 1ns/1ps
`include "adm_defines.svh"

// converter clock enable: one pulse every div system clocks
module adm_tick_div #(
  parameter int DIV = 1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  output logic tick_out
);
  import adm_pkg::*;

  localparam logic [7:0] LAST = 8'(DIV - 1);

  adm_div_state_t st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = (st_ff.cnt == LAST);
    nxt_st.cnt = (st_ff.cnt == LAST) ? 8'h00 : st_ff.cnt + 8'h01;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_out = st_ff.tick;
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "adm_defines.svh"

module tb_top;
  import adm_pkg::*;

  logic clk;
  logic rst;
  adm_cfg_t cfg;
  logic run_wr;
  logic run_wr_data;
  logic timer_match;
  logic ext_trig;
  logic [9:0] conv_data;
  logic run_flag;
  logic irq;
  adm_res_t res;
  logic [3:0] sel_ch;
  logic sel_ref;
  logic pre;
  logic dis;
  logic conv;
  int err_count;
  int checks;
  int cycles;
  int busy_n;
  adm_res_t resq[$];
  logic [3:0] irqq[$];
  logic pre_seen;
  logic dis_seen;
  logic [3:0] chs [9] = '{4'h0, 4'h1, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb,
                          4'h0};

  adm_mode_sequencer #(.AD_DIV(1)) i_adm_mode_sequencer (
    .SYS_CLK_IN(clk), .RESET_IN(rst), .CFG_IN(cfg), .RUN_WR_IN(run_wr),
    .RUN_WR_DATA_IN(run_wr_data), .TIMER_MATCH_IN(timer_match),
    .EXT_TRIG_IN(ext_trig), .CONV_DATA_IN(conv_data),
    .RUN_FLAG_OUT(run_flag), .IRQ_OUT(irq), .RES_OUT(res),
    .SEL_CH_OUT(sel_ch), .SEL_REF_OUT(sel_ref), .PRECHARGE_OUT(pre),
    .DISCHARGE_OUT(dis), .CONVERTING_OUT(conv)
  );

  adm_analog_model i_adm_analog_model (
    .clk_in(clk), .sel_ch_in(sel_ch), .sel_ref_in(sel_ref),
    .converting_in(conv), .conv_data_out(conv_data)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----
  // monitor and hang guard
  // ----
  always @(posedge clk) begin
    cycles++;
    if (res.we === 1'b1) resq.push_back(res);
    if (irq === 1'b1) irqq.push_back({res.we, res.idx});
    if (pre === 1'b1) pre_seen = 1'b1;
    if (dis === 1'b1) dis_seen = 1'b1;
    if (conv === 1'b1) busy_n++;
    if (cycles == 6000) begin
      err_count++;
      $display("ERROR run length expected below 6000 seen %0d", cycles);
      final_report();
    end
  end

  // ----
  // helpers
  // ----
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [9:0] lvl(input logic [3:0] ch, input logic rf,
                                    input logic r10);
    logic [9:0] v;
    v = rf ? 10'h3a5 : {1'b0, ch, 5'h16};
    return r10 ? v : {2'b00, v[9:2]};
  endfunction

  function automatic logic [2:0] slot(input logic [3:0] ch, input logic rf);
    if (rf) return 3'h0;
    case (ch)
      4'h1, 4'h9: return 3'h1;
      4'ha: return 3'h2;
      4'hb: return 3'h3;
      4'h5: return 3'h5;
      4'h6: return 3'h6;
      default: return 3'h0;
    endcase
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic run_write(input logic d);
    tick(1);
    run_wr = 1'b1;
    run_wr_data = d;
    tick(1);
    run_wr = 1'b0;
  endtask

  task automatic set_cfg(input adm_mode_t m, input adm_trig_t t,
                         input logic [3:0] ch, input logic rf,
                         input logic sw, input logic r10);
    adm_cfg_t c;
    tick(1);
    // built aside so the design input changes once per step
    c = '0;
    c.mode = m;
    c.trig = t;
    c.channel_select = ch[2:0];
    c.group_select = {1'b0, ch[3]};
    c.sweep_width_bit = sw;
    c.extended_input_select = rf;
    c.res_10bit = r10;
    cfg = c;
    resq.delete();
    irqq.delete();
    pre_seen = 1'b0;
    dis_seen = 1'b0;
    busy_n = 0;
  endtask

  task automatic wait_res(input int n);
    int k;
    k = 0;
    while (resq.size() < n && k < 3000) begin
      tick(1);
      k++;
    end
    if (resq.size() < n) begin
      err_count++;
      $display("ERROR results expected %0d seen %0d", n, resq.size());
    end
  endtask

  task automatic chk_res(input int i, input logic [2:0] ix,
                         input logic [9:0] d);
    cmp("result slot", {13'h0, ix}, {13'h0, resq[i].idx});
    cmp("result data", {6'h0, d}, {6'h0, resq[i].data});
  endtask

  // ----
  // tests
  // ----
  initial begin
    logic [3:0] base;
    int n;
    rst = 1'b1;
    cfg = '0;
    run_wr = 1'b0;
    run_wr_data = 1'b0;
    timer_match = 1'b0;
    ext_trig = 1'b1;
    err_count = 0;
    checks = 0;
    cycles = 0;
    pre_seen = 1'b0;
    dis_seen = 1'b0;
    tick(6);
    rst = 1'b0;

    // one pass uses the reserved trigger code, which acts as software
    for (int i = 0; i < 9; i++) begin
      set_cfg(ADM_ONE_SHOT, i == 7 ? ADM_TRIG_RSVD : ADM_TRIG_SOFT, chs[i],
              i == 8, 1'b0, i[0]);
      run_write(1'b1);
      wait_res(1);
      tick(60);
      cmp("one-shot count", 16'h1, 16'(resq.size()));
      cmp("busy cycles", 16'(`ADM_CONV_CYC), 16'(busy_n));
      chk_res(0, slot(chs[i], i == 8),
              lvl(chs[i], i == 8, i[0]));
      cmp("one-shot irq", 16'h1, 16'(irqq.size()));
      cmp("run flag", 16'h0, {15'h0, run_flag});
    end
    $display("test one_shot done");

    for (int p = 0; p < 2; p++) begin
      set_cfg(ADM_ONE_SHOT, ADM_TRIG_SOFT, 4'h5, 1'b0, 1'b0, 1'b1);
      tick(1);
      cfg.open_detect_enable = 1'b1;
      tick(1);
      cfg.open_detect_polarity = p[0];
      run_write(1'b1);
      wait_res(1);
      cmp("precharge seen", {15'h0, p[0]}, {15'h0, pre_seen});
      cmp("discharge seen", {15'h0, ~p[0]}, {15'h0, dis_seen});
      chk_res(0, 3'h5, lvl(4'h5, 1'b0, 1'b1));
    end
    $display("test assist done");

    for (int t = 0; t < 2; t++) begin
      base = 4'(9 + t);
      set_cfg(ADM_ONE_SHOT, t ? ADM_TRIG_EXT : ADM_TRIG_TIMER, base,
              1'b0, 1'b0, 1'b1);
      run_write(1'b1);
      if (t) begin
        timer_match = 1'b1;
      end else begin
        ext_trig = 1'b0;
      end
      tick(1);
      timer_match = 1'b0;
      ext_trig = 1'b1;
      tick(60);
      cmp("armed start", 16'h0, 16'(resq.size()));
      if (t) begin
        ext_trig = 1'b0;
      end else begin
        timer_match = 1'b1;
      end
      tick(1);
      timer_match = 1'b0;
      wait_res(1);
      ext_trig = 1'b1;
      chk_res(0, slot(base, 1'b0), lvl(base, 1'b0, 1'b1));
      cmp("hw irq", 16'h1, 16'(irqq.size()));
      cmp("run flag kept", 16'h1, {15'h0, run_flag});
      run_write(1'b0);
    end
    $display("test triggers done");

    set_cfg(ADM_REPEAT_QUIET, ADM_TRIG_SOFT, 4'h6, 1'b0, 1'b0, 1'b0);
    run_write(1'b1);
    wait_res(3);
    run_write(1'b0);
    n = resq.size();
    tick(100);
    cmp("stop results", 16'(n), 16'(resq.size()));
    cmp("run flag", 16'h0, {15'h0, run_flag});
    for (int i = 0; i < 3; i++) begin
      chk_res(i, 3'h6, lvl(4'h6, 1'b0, 1'b0));
    end
    cmp("quiet irq", 16'h0, 16'(irqq.size()));
    $display("test quiet repeat done");

    set_cfg(ADM_REPEAT_ROT, ADM_TRIG_SOFT, 4'hb, 1'b0, 1'b0, 1'b1);
    run_write(1'b1);
    wait_res(9);
    run_write(1'b0);
    for (int i = 0; i < 9; i++) begin
      chk_res(i, i[2:0], lvl(4'hb, 1'b0, 1'b1));
    end
    cmp("rot irq count", 16'h1, 16'(irqq.size()));
    cmp("rot irq slot", 16'hf, {12'h0, irqq[0]});
    $display("test rotating repeat done");

    for (int g = 0; g < 3; g++) begin
      base = g == 0 ? 4'h0 : 4'h8;
      n = g == 2 ? 4 : 2;
      set_cfg(ADM_SWEEP, ADM_TRIG_SOFT, base, 1'b0, g == 2, g[0]);
      run_write(1'b1);
      wait_res(n);
      tick(60);
      cmp("sweep count", 16'(n), 16'(resq.size()));
      for (int k = 0; k < n; k++) begin
        chk_res(k, 3'(k), lvl(base + 4'(k), 1'b0, g[0]));
      end
      cmp("sweep irq", 16'h1, 16'(irqq.size()));
      cmp("sweep irq last", 16'(8 + n - 1), {12'h0, irqq[0]});
      cmp("sweep run flag", 16'h0, {15'h0, run_flag});
    end
    $display("test sweep done");

    set_cfg(ADM_ONE_SHOT, ADM_TRIG_SOFT, 4'h0, 1'b1, 1'b0, 1'b1);
    run_write(1'b1);
    tick(10);
    run_write(1'b0);
    tick(80);
    cmp("abort irq", 16'h0, 16'(irqq.size()));
    cmp("abort results", 16'h0, 16'(resq.size()));
    cmp("abort run flag", 16'h0, {15'h0, run_flag});
    $display("test abort done");
    final_report();
  end
endmodule
